// ==== common/prs_cfg.svh ====
// Overview of operation
// - Bits 31:17 are reserved: writes are dropped, reads give zero.
// - Bit 16 puts CAN TX/RX on C7/C6 when clear, on E7/H2 when set.
// - Bit 15 takes pulse timer input B from B0, or from H7 when set.
// - Bit 14 takes pulse timer input A from D5, or from E2 when set.
// - Bit 13 puts third serial TX/RX on D7/D6, or on I1/I0 when set.
// - Bit 12 puts second serial TX/RX on C7/C6, or on F3/F2 when set.
// - Bit 11 puts second SPI SCK, MOSI, MISO, select on D0-D3 or G4-G7.
// - Bit 10 puts second I2C SCL/SDA on E1/E0, or on H4/H3 when set.
// - Bit 9 routes timer C channel 5 to B5 when clear, to G7 when set.
// - Bit 8 routes timer C channel 4 to B4 when clear, to G6 when set.
// - Bits 7:6 put timer C ch 3 on C3, D1 or G5; code 3 is reserved.
// - Bits 5:4 put timer C ch 2 on C2, D0 or G4; code 3 is reserved.
// - Bits 3:2 put timer C ch 1 on C1, H1 or F1; code 3 is reserved.
// - Bits 1:0 put timer C ch 0 on C0, H0 or F0; code 3 is reserved.
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

`define PRS_ADDR_W 12
`define PRS_OFF_ROUTE 12'h010
`define PRS_ROUTE_RESET 32'h00000000
`define PRS_ROUTE_WMASK 32'h0001FFFF
`define PRS_RESP_OKAY 2'h0
`define PRS_RESP_SLVERR 2'h2

`define PRS_BIT_CAN 16
`define PRS_BIT_PWT_B 15
`define PRS_BIT_PWT_A 14
`define PRS_BIT_U3 13
`define PRS_BIT_U2 12
`define PRS_BIT_SPI 11
`define PRS_BIT_I2C 10
`define PRS_BIT_TC5 9
`define PRS_BIT_TC4 8
`define PRS_F_TC3 6
`define PRS_F_TC2 4
`define PRS_F_TC1 2
`define PRS_F_TC0 0

`define PRS_NSIG 20
`define PRS_NPIN 36
`define PRS_PIN_NONE 6'h3F
`define PRS_PIN_B0 6'h00
`define PRS_PIN_B4 6'h01
`define PRS_PIN_B5 6'h02
`define PRS_PIN_C0 6'h03
`define PRS_PIN_C1 6'h04
`define PRS_PIN_C2 6'h05
`define PRS_PIN_C3 6'h06
`define PRS_PIN_C6 6'h07
`define PRS_PIN_C7 6'h08
`define PRS_PIN_D0 6'h09
`define PRS_PIN_D1 6'h0A
`define PRS_PIN_D2 6'h0B
`define PRS_PIN_D3 6'h0C
`define PRS_PIN_D5 6'h0D
`define PRS_PIN_D6 6'h0E
`define PRS_PIN_D7 6'h0F
`define PRS_PIN_E0 6'h10
`define PRS_PIN_E1 6'h11
`define PRS_PIN_E2 6'h12
`define PRS_PIN_E7 6'h13
`define PRS_PIN_F0 6'h14
`define PRS_PIN_F1 6'h15
`define PRS_PIN_F2 6'h16
`define PRS_PIN_F3 6'h17
`define PRS_PIN_G4 6'h18
`define PRS_PIN_G5 6'h19
`define PRS_PIN_G6 6'h1A
`define PRS_PIN_G7 6'h1B
`define PRS_PIN_H0 6'h1C
`define PRS_PIN_H1 6'h1D
`define PRS_PIN_H2 6'h1E
`define PRS_PIN_H3 6'h1F
`define PRS_PIN_H4 6'h20
`define PRS_PIN_H7 6'h21
`define PRS_PIN_I0 6'h22
`define PRS_PIN_I1 6'h23

`endif

// ==== common/prs_pkg.sv ====
package prs_pkg;

  // Routed signal identities; the position is also the drive priority
  typedef enum logic [4:0] {
    PRS_CAN_TX, PRS_CAN_RX, PRS_PWT_B, PRS_PWT_A,
    PRS_U3_TX, PRS_U3_RX, PRS_U2_TX, PRS_U2_RX,
    PRS_SPI_SCK, PRS_SPI_MOSI, PRS_SPI_MISO, PRS_SPI_CS,
    PRS_I2C_SCL, PRS_I2C_SDA,
    PRS_TC5, PRS_TC4, PRS_TC3, PRS_TC2, PRS_TC1, PRS_TC0
  } prs_sig_t;

  typedef logic [5:0] prs_pin_t;

  typedef struct packed {
    logic oe;
    logic o;
  } prs_drv_t;

endpackage : prs_pkg

// ==== core/prs_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module prs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : prs_sync

`default_nettype wire

// ==== core/prs_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"

module prs_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`PRS_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`PRS_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Peripheral side
  input wire prs_pkg::prs_drv_t [`PRS_NSIG-1:0] periph_drv,
  output logic [`PRS_NSIG-1:0] periph_in,
  // Port pins
  input wire logic [`PRS_NPIN-1:0] pin_in,
  output logic [`PRS_NPIN-1:0] pin_out,
  output logic [`PRS_NPIN-1:0] pin_oe
);
  import prs_pkg::*;

  localparam logic [`PRS_ADDR_W-1:0] OFF_ROUTE = `PRS_OFF_ROUTE;
  localparam logic [31:0] WMASK = `PRS_ROUTE_WMASK;

  logic [31:0] pin_route_select_two;
  logic [`PRS_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [`PRS_NPIN-1:0] pin_s;
  logic [`PRS_NPIN-1:0] next_pin_out;
  logic [`PRS_NPIN-1:0] next_pin_oe;
  logic [`PRS_NSIG-1:0] next_periph_in;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [`PRS_ADDR_W-1:0] a);
    addr_hit = (a[`PRS_ADDR_W-1:2] == OFF_ROUTE[`PRS_ADDR_W-1:2]);
  endfunction : addr_hit

  // Three-way field; the reserved code leaves the channel unrouted
  function automatic prs_pin_t tri_sel(input logic [1:0] code,
                                       input prs_pin_t p0,
                                       input prs_pin_t p1,
                                       input prs_pin_t p2);
    case (code)
      2'h0: tri_sel = p0;
      2'h1: tri_sel = p1;
      2'h2: tri_sel = p2;
      default: tri_sel = `PRS_PIN_NONE;
    endcase
  endfunction : tri_sel

  function automatic prs_pin_t route_pin(input prs_sig_t s,
                                         input logic [31:0] r);
    logic c;
    c = r[`PRS_BIT_CAN];
    case (s)
      PRS_CAN_TX: route_pin = c ? `PRS_PIN_E7 : `PRS_PIN_C7;
      PRS_CAN_RX: route_pin = c ? `PRS_PIN_H2 : `PRS_PIN_C6;
      PRS_PWT_B: route_pin = r[`PRS_BIT_PWT_B] ?
                             `PRS_PIN_H7 : `PRS_PIN_B0;
      PRS_PWT_A: route_pin = r[`PRS_BIT_PWT_A] ?
                             `PRS_PIN_E2 : `PRS_PIN_D5;
      PRS_U3_TX: route_pin = r[`PRS_BIT_U3] ?
                             `PRS_PIN_I1 : `PRS_PIN_D7;
      PRS_U3_RX: route_pin = r[`PRS_BIT_U3] ?
                             `PRS_PIN_I0 : `PRS_PIN_D6;
      PRS_U2_TX: route_pin = r[`PRS_BIT_U2] ?
                             `PRS_PIN_F3 : `PRS_PIN_C7;
      PRS_U2_RX: route_pin = r[`PRS_BIT_U2] ?
                             `PRS_PIN_F2 : `PRS_PIN_C6;
      PRS_SPI_SCK: route_pin = r[`PRS_BIT_SPI] ?
                               `PRS_PIN_G4 : `PRS_PIN_D0;
      PRS_SPI_MOSI: route_pin = r[`PRS_BIT_SPI] ?
                                `PRS_PIN_G5 : `PRS_PIN_D1;
      PRS_SPI_MISO: route_pin = r[`PRS_BIT_SPI] ?
                                `PRS_PIN_G6 : `PRS_PIN_D2;
      PRS_SPI_CS: route_pin = r[`PRS_BIT_SPI] ?
                              `PRS_PIN_G7 : `PRS_PIN_D3;
      PRS_I2C_SCL: route_pin = r[`PRS_BIT_I2C] ?
                               `PRS_PIN_H4 : `PRS_PIN_E1;
      PRS_I2C_SDA: route_pin = r[`PRS_BIT_I2C] ?
                               `PRS_PIN_H3 : `PRS_PIN_E0;
      PRS_TC5: route_pin = r[`PRS_BIT_TC5] ?
                           `PRS_PIN_G7 : `PRS_PIN_B5;
      PRS_TC4: route_pin = r[`PRS_BIT_TC4] ?
                           `PRS_PIN_G6 : `PRS_PIN_B4;
      PRS_TC3: route_pin = tri_sel(r[`PRS_F_TC3 +: 2], `PRS_PIN_C3,
                           `PRS_PIN_D1, `PRS_PIN_G5);
      PRS_TC2: route_pin = tri_sel(r[`PRS_F_TC2 +: 2], `PRS_PIN_C2,
                           `PRS_PIN_D0, `PRS_PIN_G4);
      PRS_TC1: route_pin = tri_sel(r[`PRS_F_TC1 +: 2], `PRS_PIN_C1,
                           `PRS_PIN_H1, `PRS_PIN_F1);
      PRS_TC0: route_pin = tri_sel(r[`PRS_F_TC0 +: 2], `PRS_PIN_C0,
                           `PRS_PIN_H0, `PRS_PIN_F0);
      default: route_pin = `PRS_PIN_NONE;
    endcase
  endfunction : route_pin

  // ---------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------
  // Address and data are taken in either order; each ready stays low
  // until the response is accepted, so one write is in flight at most.
  assign do_write = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      awaddr_q <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `PRS_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= addr_hit(awaddr_q) ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Route register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_route_select_two <= `PRS_ROUTE_RESET;
    end else if (do_write && addr_hit(awaddr_q)) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          // Reserved bits are masked so they never hold a one
          pin_route_select_two[8*b +: 8] <= wdata_q[8*b +: 8] &
                                            WMASK[8*b +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `PRS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= addr_hit(araddr) ? pin_route_select_two
                                : 32'h00000000;
      rresp <= addr_hit(araddr) ? `PRS_RESP_OKAY : `PRS_RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin multiplexer
  // ---------------------------------------------------------------
  prs_sync #(
    .W(`PRS_NPIN)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_in),
    .q(pin_s)
  );

  // Shared pins go to the lowest numbered signal that drives them;
  // software is expected to avoid such overlaps.
  always_comb begin
    prs_pin_t p;
    p = `PRS_PIN_NONE;
    next_pin_out = '0;
    next_pin_oe = '0;
    next_periph_in = '0;
    for (int s = `PRS_NSIG - 1; s >= 0; s--) begin
      p = route_pin(prs_sig_t'(s), pin_route_select_two);
      if (p != `PRS_PIN_NONE) begin
        next_periph_in[s] = pin_s[p];
        if (periph_drv[s].oe) begin
          next_pin_oe[p] = 1'b1;
          next_pin_out[p] = periph_drv[s].o;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      periph_in <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      periph_in <= next_periph_in;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reserved_bits_zero: assert property (
    (rvalid && rresp == `PRS_RESP_OKAY) |-> rdata[31:17] == 15'h0000)
    else $error("reserved route bits read nonzero");

  a_reset_clears_route: assert property (
    $rose(aresetn) |-> pin_route_select_two == `PRS_ROUTE_RESET &&
      pin_oe == '0)
    else $error("route register not clear after reset");

  a_can_tx_default: assert property (
    (!pin_route_select_two[`PRS_BIT_CAN] && periph_drv[PRS_CAN_TX].oe) |=>
      pin_oe[`PRS_PIN_C7] &&
      pin_out[`PRS_PIN_C7] == $past(periph_drv[PRS_CAN_TX].o))
    else $error("CAN transmit not on default pin");

  a_can_rx_alt: assert property (
    pin_route_select_two[`PRS_BIT_CAN] |=>
      periph_in[PRS_CAN_RX] == $past(pin_s[`PRS_PIN_H2]))
    else $error("CAN receive not from alternate pin");

  a_pwt_b_alt: assert property (
    pin_route_select_two[`PRS_BIT_PWT_B] |=>
      periph_in[PRS_PWT_B] == $past(pin_s[`PRS_PIN_H7]))
    else $error("pulse timer B not from alternate pin");

  a_pwt_a_default: assert property (
    !pin_route_select_two[`PRS_BIT_PWT_A] |=>
      periph_in[PRS_PWT_A] == $past(pin_s[`PRS_PIN_D5]))
    else $error("pulse timer A not from default pin");

  a_serial3_tx_alt: assert property (
    (pin_route_select_two[`PRS_BIT_U3] && periph_drv[PRS_U3_TX].oe) |=>
      pin_oe[`PRS_PIN_I1] &&
      pin_out[`PRS_PIN_I1] == $past(periph_drv[PRS_U3_TX].o))
    else $error("third serial transmit not on alternate pin");

  a_serial2_rx_alt: assert property (
    pin_route_select_two[`PRS_BIT_U2] |=>
      periph_in[PRS_U2_RX] == $past(pin_s[`PRS_PIN_F2]))
    else $error("second serial receive not from alternate pin");

  a_spi_miso_alt: assert property (
    pin_route_select_two[`PRS_BIT_SPI] |=>
      periph_in[PRS_SPI_MISO] == $past(pin_s[`PRS_PIN_G6]))
    else $error("SPI MISO not from alternate pin");

  a_i2c_sda_default: assert property (
    !pin_route_select_two[`PRS_BIT_I2C] |=>
      periph_in[PRS_I2C_SDA] == $past(pin_s[`PRS_PIN_E0]))
    else $error("I2C data not from default pin");

  a_tc1_code_one: assert property (
    (pin_route_select_two[`PRS_F_TC1 +: 2] == 2'h1 &&
     periph_drv[PRS_TC1].oe) |=>
      pin_oe[`PRS_PIN_H1] &&
      pin_out[`PRS_PIN_H1] == $past(periph_drv[PRS_TC1].o))
    else $error("timer channel 1 code 1 not on its pin");

  a_tc0_reserved: assert property (
    pin_route_select_two[`PRS_F_TC0 +: 2] == 2'h3 |=>
      !pin_oe[`PRS_PIN_C0])
    else $error("timer channel 0 driven under reserved code");

  a_tc5_alt_drive: assert property (
    (pin_route_select_two[`PRS_BIT_TC5] && periph_drv[PRS_TC5].oe &&
     !periph_drv[PRS_SPI_CS].oe) |=>
      pin_oe[`PRS_PIN_G7] &&
      pin_out[`PRS_PIN_G7] == $past(periph_drv[PRS_TC5].o))
    else $error("timer channel 5 not on alternate pin");

  a_tc4_default: assert property (
    (!pin_route_select_two[`PRS_BIT_TC4] && periph_drv[PRS_TC4].oe) |=>
      pin_oe[`PRS_PIN_B4] &&
      pin_out[`PRS_PIN_B4] == $past(periph_drv[PRS_TC4].o))
    else $error("timer channel 4 not on default pin");

  a_tc3_code_two: assert property (
    (pin_route_select_two[`PRS_F_TC3 +: 2] == 2'h2 &&
     periph_drv[PRS_TC3].oe && !periph_drv[PRS_SPI_MOSI].oe) |=>
      pin_oe[`PRS_PIN_G5] &&
      pin_out[`PRS_PIN_G5] == $past(periph_drv[PRS_TC3].o))
    else $error("timer channel 3 code 2 not on its pin");

  a_tc2_code_one: assert property (
    (pin_route_select_two[`PRS_F_TC2 +: 2] == 2'h1 &&
     periph_drv[PRS_TC2].oe && !periph_drv[PRS_SPI_SCK].oe) |=>
      pin_oe[`PRS_PIN_D0] &&
      pin_out[`PRS_PIN_D0] == $past(periph_drv[PRS_TC2].o))
    else $error("timer channel 2 code 1 not on its pin");

  a_write_response: assert property (
    do_write |=> bvalid ##0 !awready ##0 !wready)
    else $error("write response missing");

  c_route_write: cover property (do_write && addr_hit(awaddr_q));
  c_route_read: cover property (rvalid && rready && rdata != '0);
  c_can_alt_drive: cover property (pin_route_select_two[`PRS_BIT_CAN] &&
                                   pin_oe[`PRS_PIN_E7]);
  c_tc3_third_pin: cover property (
    pin_route_select_two[`PRS_F_TC3 +: 2] == 2'h2);

endmodule : prs_top

`default_nettype wire

// ==== dv/prs_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"

module prs_pin_model (
  // Pin side of the device
  input wire logic [`PRS_NPIN-1:0] pin_out,
  input wire logic [`PRS_NPIN-1:0] pin_oe,
  // Level the board puts on pins the device leaves alone
  input wire logic [`PRS_NPIN-1:0] ext_lvl,
  output logic [`PRS_NPIN-1:0] pin_in
);
  // No pulls: an undriven pin shows only what the board applies
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : prs_pin_model

`default_nettype wire

// ==== dv/prs_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "prs_cfg.svh"

module prs_tb_top;
  import prs_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [`PRS_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  prs_drv_t [`PRS_NSIG-1:0] drv;
  logic [`PRS_NSIG-1:0] periph_in;
  logic [`PRS_NPIN-1:0] pin_in, pin_out, pin_oe, ext_lvl;
  logic [15:0] seed;
  logic [31:0] r;
  int err_total, n_compared, cycles;

  prs_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .periph_drv(drv), .periph_in(periph_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  prs_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  function automatic prs_pin_t pick3(input logic [1:0] c,
                                     input prs_pin_t a, b, e);
    return (c == 2'h0) ? a : (c == 2'h1) ? b :
           (c == 2'h2) ? e : `PRS_PIN_NONE;
  endfunction : pick3

  function automatic prs_pin_t exp_pin(input int s, input logic [31:0] v);
    case (s)
      0: return v[16] ? `PRS_PIN_E7 : `PRS_PIN_C7;
      1: return v[16] ? `PRS_PIN_H2 : `PRS_PIN_C6;
      2: return v[15] ? `PRS_PIN_H7 : `PRS_PIN_B0;
      3: return v[14] ? `PRS_PIN_E2 : `PRS_PIN_D5;
      4: return v[13] ? `PRS_PIN_I1 : `PRS_PIN_D7;
      5: return v[13] ? `PRS_PIN_I0 : `PRS_PIN_D6;
      6: return v[12] ? `PRS_PIN_F3 : `PRS_PIN_C7;
      7: return v[12] ? `PRS_PIN_F2 : `PRS_PIN_C6;
      8: return v[11] ? `PRS_PIN_G4 : `PRS_PIN_D0;
      9: return v[11] ? `PRS_PIN_G5 : `PRS_PIN_D1;
      10: return v[11] ? `PRS_PIN_G6 : `PRS_PIN_D2;
      11: return v[11] ? `PRS_PIN_G7 : `PRS_PIN_D3;
      12: return v[10] ? `PRS_PIN_H4 : `PRS_PIN_E1;
      13: return v[10] ? `PRS_PIN_H3 : `PRS_PIN_E0;
      14: return v[9] ? `PRS_PIN_G7 : `PRS_PIN_B5;
      15: return v[8] ? `PRS_PIN_G6 : `PRS_PIN_B4;
      16: return pick3(v[7:6], `PRS_PIN_C3, `PRS_PIN_D1,
                       `PRS_PIN_G5);
      17: return pick3(v[5:4], `PRS_PIN_C2, `PRS_PIN_D0,
                       `PRS_PIN_G4);
      18: return pick3(v[3:2], `PRS_PIN_C1, `PRS_PIN_H1,
                       `PRS_PIN_F1);
      default: return pick3(v[1:0], `PRS_PIN_C0, `PRS_PIN_H0,
                            `PRS_PIN_F0);
    endcase
  endfunction : exp_pin

  function automatic logic [`PRS_NPIN-1:0] exp_oe(input prs_pin_t p);
    return (p == `PRS_PIN_NONE) ? '0 : (36'h1 << p);
  endfunction : exp_oe

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rd

  // Drive each signal alone, then read every input back from the pins
  task automatic mux_pass(input logic [31:0] v);
    prs_drv_t [`PRS_NSIG-1:0] dv;
    logic [`PRS_NSIG-1:0] ein;
    prs_pin_t p;
    wr(`PRS_OFF_ROUTE, v, 4'hF);
    rd(`PRS_OFF_ROUTE);
    chk(d, v & 32'h0001FFFF);
    for (int s = 0; s < `PRS_NSIG; s++) begin
      seed = lfsr(seed);
      p = exp_pin(s, v);
      dv = '0;
      dv[s] = {1'h1, seed[0]};
      @(posedge aclk);
      drv <= dv;
      repeat (2) @(posedge aclk);
      chk(pin_oe, exp_oe(p));
      chk(pin_out & exp_oe(p), seed[0] ? exp_oe(p) : '0);
    end
    @(posedge aclk);
    drv <= '0;
    ext_lvl <= {seed, ~seed, seed[3:0]};
    repeat (5) @(posedge aclk);
    for (int s = 0; s < `PRS_NSIG; s++) begin
      p = exp_pin(s, v);
      ein[s] = (p == `PRS_PIN_NONE) ? 1'h0 : ext_lvl[p];
    end
    chk(periph_in, ein);
  endtask : mux_pass

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, drv, ext_lvl} = '0;
    {err_total, n_compared, cycles} = '0;
    seed = 16'h003D;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    chk(pin_oe, '0);
    rd(`PRS_OFF_ROUTE);
    chk(d, `PRS_ROUTE_RESET);
    wr(`PRS_OFF_ROUTE, 32'hFFFFFFAA, 4'hF);
    chk(resp, `PRS_RESP_OKAY);
    wr(`PRS_OFF_ROUTE, 32'hFFFF55FF, 4'h2);
    rd(`PRS_OFF_ROUTE);
    chk(d, 32'h000155AA);
    wr(12'h014, 32'h00000000, 4'hF);
    chk(resp, `PRS_RESP_SLVERR);
    rd(12'h014);
    chk({d, resp}, {32'h0, `PRS_RESP_SLVERR});
    rd(`PRS_OFF_ROUTE);
    chk(d, 32'h000155AA);
    mux_pass(32'h00000000);
    mux_pass(32'h0001FFAA);
    mux_pass(32'h00015555);
    // Reserved code on one channel: that channel must reach no pin
    mux_pass(32'h00000003);
    repeat (25) begin
      seed = lfsr(seed);
      r = {15'h0, seed[0], lfsr(seed)};
      seed = lfsr(seed);
      for (int k = 0; k < 4; k++) begin
        if (r[2*k +: 2] == 2'h3) r[2*k +: 2] = 2'h1;
      end
      mux_pass(r);
    end
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`PRS_OFF_ROUTE);
    chk(d, `PRS_ROUTE_RESET);
    close_out();
  end
endmodule : prs_tb_top

`default_nettype wire
